// ---- shared/csfp_pkg.sv ----
// Shared constants and types of the slave serial frame port
package csfp_pkg;
  localparam int          WORD_BITS   = 16;
  localparam int          CNT_W       = 4;
  localparam logic [3:0]  LAST_BIT    = 4'hf;
  localparam logic [3:0]  FIRST_BIT   = 4'h0;
  localparam int          FIFO_DEPTH  = 32;
  localparam int          FSD_W       = 8;
  localparam logic [7:0]  FSD_ZERO    = 8'h00;
  localparam int          DAC_LSB     = 2;
  localparam int          DAC_BITS    = 14;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  localparam logic [15:0] WORD_MAX    = 16'h7fff;
  localparam logic [15:0] WORD_MIN    = 16'h8000;
  // Input gain field codes
  localparam logic [1:0]  GAIN_SQUELCH = 2'h0;
  localparam logic [1:0]  GAIN_LOW     = 2'h1;
  localparam logic [1:0]  GAIN_MID     = 2'h2;
  localparam logic [1:0]  GAIN_HIGH    = 2'h3;
  // Synchroniser lane order and idle levels: frame sync, shift clock, data in
  localparam int          PIN_FS   = 2;
  localparam int          PIN_SCLK = 1;
  localparam int          PIN_DIN  = 0;
  localparam logic [2:0]  PIN_IDLE = 3'h4;

  typedef struct packed {
    logic [13:0] dac;
    logic [1:0]  ctrl;
  } csfp_rx_t;

  typedef enum logic [1:0] {
    CSFP_IDLE,
    CSFP_LOAD,
    CSFP_ACTIVE
  } csfp_state_t;
endpackage

// ---- design/csfp_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module csfp_sync
  import csfp_pkg::*;
#(
  parameter int             W    = 3,
  parameter logic [W-1:0]   INIT = '0
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] stage1;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1   <= INIT;
      pin_sync <= INIT;
    end else begin
      stage1   <= pin_in;
      pin_sync <= stage1;
    end
  end
endmodule // csfp_sync

// ---- design/csfp_fifo.sv ----
// Sample FIFO with registered read data
`timescale 1ns/100ps
module csfp_fifo
  import csfp_pkg::*;
#(
  parameter int WIDTH = WORD_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side; data appear the cycle after the handshake
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_data <= '0;
    end else if (pop) begin
      out_data <= mem[rd_ptr];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // csfp_fifo

// ---- design/csfp_port.sv ----
// Slave serial frame port: 16-bit shift link, delayed frame sync, input gain
//
// What this block does
// - Outgoing D15 appears at frame start; later bits change on shift clock rising edges.
// - Incoming bits are captured on shift clock falling edges.
// - Each frame sync falling edge starts one new conversion frame.
// - Words are 16 bits, most significant bit first on both lines.
// - Delayed frame sync falls the programmed number of shift clocks after sync.
// - With zero delay, delayed sync falls straight from the frame sync fall.
// - One delay value serves every link in a master-slave chain.
// - Gain code 00 squelches; 01, 10, 11 give rising gain.
// - Incoming bits 15 to 2 form the sample; bits 1 and 0 are control.
`timescale 1ns/100ps
module csfp_port
  import csfp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Link pins from the far side
  input  wire logic             shift_clk,
  input  wire logic             frame_sync_n,
  input  wire logic             serial_in,
  // Link pins to the far side
  output logic                  serial_out,
  output logic                  serial_out_oe,
  output logic                  delayed_frame_sync_out,
  // Configuration levels
  input  wire logic [FSD_W-1:0] fs_delay,
  input  wire logic             gain_sel_hi,
  input  wire logic             gain_sel_lo,
  // Converter samples to send
  input  wire logic             adc_valid,
  output logic                  adc_ready,
  input  wire logic [15:0]      adc_sample,
  // Received samples
  output logic                  rx_valid,
  output csfp_rx_t              rx_word
);
  logic [2:0]       pins;
  logic             fs_prev;
  logic             sclk_prev;
  logic             fs_fall;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             din;
  csfp_state_t      state;
  logic [15:0]      tx_shift;
  logic [15:0]      tx_load;
  logic [CNT_W-1:0] tx_cnt;
  logic             tx_pend;
  logic [15:0]      rx_shift;
  logic [CNT_W-1:0] rx_cnt;
  logic [15:0]      rx_next;
  logic             popped;
  logic             fifo_valid;
  logic [15:0]      fifo_data;
  logic [FSD_W-1:0] fsd_cnt;
  logic             fsd_armed;
  logic [1:0]       gain_code;

  // Saturating gain; from code 01 up each step doubles the level
  function automatic logic [15:0] gain_apply(input logic [15:0] s, input logic [1:0] code);
    logic [15:0] r;
    r = s;
    unique case (code)
      GAIN_SQUELCH: r = WORD_ZERO;
      GAIN_LOW:     r = s;
      GAIN_MID:     r = (s[15] != s[14]) ? (s[15] ? WORD_MIN : WORD_MAX) : {s[14:0], 1'b0};
      GAIN_HIGH:    r = (s[15:13] != {3{s[15]}}) ? (s[15] ? WORD_MIN : WORD_MAX)
                                                 : {s[13:0], 2'b00};
    endcase
    return r;
  endfunction

  // Pins come from the far side's clock, so all three pass two flops
  csfp_sync #(.W(3), .INIT(PIN_IDLE)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   ({frame_sync_n, shift_clk, serial_in}),
    .pin_sync (pins)
  );

  csfp_fifo #(.WIDTH(WORD_BITS), .DEPTH(DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (adc_valid),
    .in_ready  (adc_ready),
    .in_data   (adc_sample),
    .out_valid (fifo_valid),
    .out_ready (fs_fall),
    .out_data  (fifo_data)
  );

  assign gain_code = {gain_sel_hi, gain_sel_lo};
  assign din       = pins[PIN_DIN];
  // Shift clock and frame sync are inputs only; this end never drives them
  assign fs_fall   = fs_prev && !pins[PIN_FS];
  assign sclk_rise = !sclk_prev && pins[PIN_SCLK];
  assign sclk_fall = sclk_prev && !pins[PIN_SCLK];
  assign rx_next   = {rx_shift[14:0], din};
  // Word that leaves at frame start; an empty buffer sends zeros
  assign tx_load   = gain_apply(popped ? fifo_data : WORD_ZERO, gain_code);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fs_prev   <= PIN_IDLE[PIN_FS];
      sclk_prev <= PIN_IDLE[PIN_SCLK];
    end else begin
      fs_prev   <= pins[PIN_FS];
      sclk_prev <= pins[PIN_SCLK];
    end
  end

  // Frame sequencing; a new frame sync fall restarts even a frame in flight
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= CSFP_IDLE;
    end else if (fs_fall) begin
      state <= CSFP_LOAD;
    end else begin
      unique case (state)
        CSFP_IDLE:   state <= CSFP_IDLE;
        CSFP_LOAD:   state <= CSFP_ACTIVE;
        CSFP_ACTIVE: if (sclk_rise && tx_pend && tx_cnt == LAST_BIT) state <= CSFP_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      popped <= 1'b0;
    end else begin
      popped <= fs_fall && fifo_valid;
    end
  end

  // Transmit: MSB out at frame start, then one bit per rising edge, but only
  // after a falling edge has taken the current bit, so a sync fall that lands
  // on a rising edge cannot skip D15
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_shift      <= WORD_ZERO;
      tx_cnt        <= FIRST_BIT;
      tx_pend       <= 1'b0;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (fs_fall) begin
      tx_cnt        <= FIRST_BIT;
      tx_pend       <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (state == CSFP_LOAD) begin
      tx_shift      <= tx_load;
      serial_out    <= tx_load[WORD_BITS-1];
      serial_out_oe <= 1'b1;
    end else if (state == CSFP_ACTIVE) begin
      if (sclk_fall) begin
        tx_pend <= 1'b1;
      end else if (sclk_rise && tx_pend) begin
        tx_pend <= 1'b0;
        if (tx_cnt == LAST_BIT) begin
          serial_out_oe <= 1'b0;
        end else begin
          tx_cnt     <= tx_cnt + 1'b1;
          tx_shift   <= {tx_shift[14:0], 1'b0};
          serial_out <= tx_shift[14];
        end
      end
    end
  end

  // Receive: one bit per falling edge, 16 bits MSB first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_shift <= WORD_ZERO;
      rx_cnt   <= FIRST_BIT;
      rx_valid <= 1'b0;
      rx_word  <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (fs_fall) begin
        rx_cnt <= FIRST_BIT;
      end else if (state == CSFP_ACTIVE && sclk_fall && !tx_pend) begin
        rx_shift <= rx_next;
        rx_cnt   <= rx_cnt + 1'b1;
        if (rx_cnt == LAST_BIT) begin
          rx_valid     <= 1'b1;
          rx_word.dac  <= rx_next[WORD_BITS-1:DAC_LSB];
          rx_word.ctrl <= rx_next[DAC_LSB-1:0];
        end
      end
    end
  end

  // Delayed frame sync: low for one shift clock, m rising edges after sync.
  // The same delay value drives every device in a chain, so each hop matches.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fsd_cnt                <= FSD_ZERO;
      fsd_armed              <= 1'b0;
      delayed_frame_sync_out <= 1'b1;
    end else if (fs_fall) begin
      fsd_cnt                <= FSD_ZERO;
      fsd_armed              <= (fs_delay != FSD_ZERO);
      delayed_frame_sync_out <= (fs_delay != FSD_ZERO);
    end else if (sclk_rise) begin
      if (!delayed_frame_sync_out) begin
        delayed_frame_sync_out <= 1'b1;
      end else if (fsd_armed && fsd_cnt + 1'b1 == fs_delay) begin
        fsd_armed              <= 1'b0;
        delayed_frame_sync_out <= 1'b0;
      end
      if (fsd_armed) begin
        fsd_cnt <= fsd_cnt + 1'b1;
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_out_on_rise;
    $changed(serial_out) |-> $past(sclk_rise) || $past(state == CSFP_LOAD);
  endproperty
  a_out_on_rise: assert property (p_out_on_rise) else $error("data out moved off a rising edge");

  property p_in_on_fall;
    (rx_cnt != $past(rx_cnt)) |-> $past(sclk_fall) || $past(fs_fall);
  endproperty
  a_in_on_fall: assert property (p_in_on_fall) else $error("bit taken off a falling edge");

  property p_frame_start;
    fs_fall |=> state == CSFP_LOAD ##1 state == CSFP_ACTIVE && serial_out_oe;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not start on sync");

  property p_msb_first;
    (state == CSFP_LOAD && !fs_fall) |=> serial_out == tx_shift[15] && tx_cnt == FIRST_BIT;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not the MSB");

  property p_rx_split;
    (state == CSFP_ACTIVE && sclk_fall && !tx_pend && !fs_fall && rx_cnt == LAST_BIT)
      |=> rx_valid && rx_word == $past(rx_next) ##1 !rx_valid;
  endproperty
  a_rx_split: assert property (p_rx_split) else $error("received word split wrong");

  property p_fsd_count;
    (sclk_rise && !fs_fall && fsd_armed && delayed_frame_sync_out && fsd_cnt + 1'b1 == fs_delay)
      |=> !delayed_frame_sync_out;
  endproperty
  a_fsd_count: assert property (p_fsd_count) else $error("delayed sync missed its count");

  property p_fsd_zero;
    (fs_fall && fs_delay == FSD_ZERO) |=> !delayed_frame_sync_out && !fsd_armed;
  endproperty
  a_fsd_zero: assert property (p_fsd_zero) else $error("zero delay sync not immediate");

  property p_squelch;
    (state == CSFP_LOAD && !fs_fall && gain_code == GAIN_SQUELCH) |=> tx_shift == WORD_ZERO;
  endproperty
  a_squelch: assert property (p_squelch) else $error("squelch did not zero the word");

  property p_oe_window;
    serial_out_oe |-> state == CSFP_ACTIVE || $past(state == CSFP_ACTIVE);
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("data out driven outside a frame");

  property p_rx_pulse;
    rx_valid |=> !rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive strobe longer than one cycle");

  property p_fsd_one_clock;
    (!delayed_frame_sync_out && sclk_rise && !fs_fall) |=> delayed_frame_sync_out;
  endproperty
  a_fsd_one_clock: assert property (p_fsd_one_clock) else $error("delayed sync held too long");

  property p_tx_shift_order;
    (state == CSFP_ACTIVE && sclk_rise && tx_pend && tx_cnt != LAST_BIT && !fs_fall)
      |=> serial_out == $past(tx_shift[14]) && tx_cnt == $past(tx_cnt) + 1'b1;
  endproperty
  a_tx_shift_order: assert property (p_tx_shift_order) else $error("bits left out of order");

  property p_oe_close;
    (state == CSFP_ACTIVE && sclk_rise && tx_pend && tx_cnt == LAST_BIT && !fs_fall)
      |=> !serial_out_oe && state == CSFP_IDLE;
  endproperty
  a_oe_close: assert property (p_oe_close) else $error("data out not released after D0");

  property p_d15_guard;
    (state == CSFP_ACTIVE && sclk_rise && !tx_pend && !fs_fall)
      |=> $stable(serial_out) && $stable(tx_cnt);
  endproperty
  a_d15_guard: assert property (p_d15_guard) else $error("bit moved before it was taken");

  property p_pop_on_sync;
    popped |-> $past(fs_fall);
  endproperty
  a_pop_on_sync: assert property (p_pop_on_sync) else $error("sample taken off a frame start");

  property p_idle_no_capture;
    (state == CSFP_IDLE && !fs_fall) |=> $stable(rx_cnt) && !rx_valid;
  endproperty
  a_idle_no_capture: assert property (p_idle_no_capture) else $error("bit taken outside a frame");
endmodule // csfp_port

// ---- bench/csfp_dsp_model.sv ----
// Far-side serial port model: supplies shift clock and frame sync, swaps one word per frame
`timescale 1ns/100ps
module csfp_dsp_model (
  // Bench clock, used only to pace the pins
  input  wire logic sys_clk,
  // Link pins towards the port
  output logic      shift_clk,
  output logic      frame_sync_n,
  output logic      serial_in,
  // Link pins from the port
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  int rise_cnt;

  initial begin
    shift_clk    = 1'b0;
    frame_sync_n = 1'b1;
    serial_in    = 1'b0;
    rise_cnt     = 0;
  end

  // Half of a 160 ns shift clock period, edges aligned to bench drive points
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask

  // One frame: sync fall, 16 bits each way, then a closing rise to end the drive
  task automatic frame(input logic [15:0] din, input bit codec, output logic [15:0] dout,
                       output logic oe_ok);
    oe_ok    = 1'b1;
    dout     = 16'h0000;
    rise_cnt = 0;
    @(negedge sys_clk);
    frame_sync_n = 1'b0;
    // Codec emulation: sync falls one bench cycle, inside a quarter shift clock, before a rise
    if (codec) begin
      @(negedge sys_clk);
    end else begin
      half();
      half();
    end
    for (int k = 0; k <= 16; k++) begin
      // Sampled late, well after the previous fall, to clear the port's pin latency
      if (k > 0) begin
        dout  = {dout[14:0], serial_out};
        oe_ok = oe_ok & serial_out_oe;
      end
      shift_clk = 1'b1;
      rise_cnt++;
      serial_in = (k < 16) ? din[15-k] : ~serial_in;
      half();
      if (k < 16) begin
        shift_clk    = 1'b0;
        frame_sync_n = 1'b1;
        half();
      end
    end
    shift_clk = 1'b0;
    half();
    oe_ok     = oe_ok & ~serial_out_oe;
    serial_in = ~serial_in;
  endtask
endmodule // csfp_dsp_model

// ---- bench/csfp_port_tb.sv ----
// Self-checking bench of the slave serial frame port
`timescale 1ns/100ps
module csfp_port_tb;
  import csfp_pkg::*;

  logic             sys_clk;
  logic             rst_n;
  logic             shift_clk;
  logic             frame_sync_n;
  logic             serial_in;
  logic             serial_out;
  logic             serial_out_oe;
  logic             delayed_frame_sync_out;
  logic [FSD_W-1:0] fs_delay;
  logic             gain_sel_hi;
  logic             gain_sel_lo;
  logic             adc_valid;
  logic             adc_ready;
  logic [15:0]      adc_sample;
  logic             rx_valid;
  csfp_rx_t         rx_word;
  int               mismatches;
  int               tests_run;
  int               rx_cnt;
  int               fsd_cnt;
  int               fsd_at;

  csfp_port #(.DEPTH(FIFO_DEPTH)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .shift_clk(shift_clk), .frame_sync_n(frame_sync_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .delayed_frame_sync_out(delayed_frame_sync_out), .fs_delay(fs_delay),
    .gain_sel_hi(gain_sel_hi), .gain_sel_lo(gain_sel_lo), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .adc_sample(adc_sample), .rx_valid(rx_valid), .rx_word(rx_word)
  );

  csfp_dsp_model dsp (
    .sys_clk(sys_clk), .shift_clk(shift_clk), .frame_sync_n(frame_sync_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) if (rx_valid === 1'b1) rx_cnt++;
  always @(negedge delayed_frame_sync_out) if (rst_n === 1'b1) begin
    fsd_at = dsp.rise_cnt;
    fsd_cnt++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Outgoing word after gain, clipped to the 16-bit two's complement range
  function automatic logic [15:0] gained(input logic [15:0] s, input logic [1:0] g);
    int v;
    v = $signed(s);
    v = (g == GAIN_SQUELCH) ? 0 : v <<< (g - 1);
    if (v > 32767) return WORD_MAX;
    if (v < -32768) return WORD_MIN;
    return v[15:0];
  endfunction

  task automatic push(input logic [15:0] d, output logic ready);
    @(negedge sys_clk);
    adc_valid  = 1'b1;
    adc_sample = d;
    ready      = adc_ready;
    @(negedge sys_clk);
    adc_valid  = 1'b0;
  endtask

  task automatic t_gain_frames();
    logic [15:0] samp [2];
    logic [15:0] din;
    logic [15:0] dout;
    logic        ok;
    int          n;
    samp = '{16'h2345, 16'hc000};
    for (int g = 0; g < 4; g++) begin
      for (int i = 0; i < 2; i++) begin
        @(negedge sys_clk);
        {gain_sel_hi, gain_sel_lo} = 2'(g);
        din = 16'ha5c3 ^ 16'(g * 16'h1111 + i);
        n   = rx_cnt;
        push(samp[i], ok);
        dsp.frame(din, (i == 1), dout, ok);
        check(dout, gained(samp[i], 2'(g)));
        check({15'h0000, ok}, 16'h0001);
        check(16'(rx_cnt - n), 16'h0001);
        check(16'(rx_word.dac), {2'b00, din[15:2]});
        check(16'(rx_word.ctrl), 16'(din[1:0]));
      end
    end
    $display("t_gain_frames finished");
  endtask

  task automatic t_fs_delay();
    int          m [4];
    logic [15:0] dout;
    logic        ok;
    m = '{0, 1, 5, 17};
    {gain_sel_hi, gain_sel_lo} = GAIN_LOW;
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      fs_delay = 8'(m[i]);
      fsd_at   = -1;
      fsd_cnt  = 0;
      dsp.frame(16'h5a5a, 1'b0, dout, ok);
      check(16'(fsd_at), 16'(m[i]));
      check(16'(fsd_cnt), 16'h0001);
    end
    fs_delay = FSD_ZERO;
    $display("t_fs_delay finished");
  endtask

  // Fill the buffer until it refuses, then drain it one frame per word past empty
  task automatic t_fifo_fill_drain();
    logic [15:0] dout;
    logic        ok;
    {gain_sel_hi, gain_sel_lo} = GAIN_LOW;
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      push(16'h0100 + 16'(i), ok);
      check({15'h0000, ok}, (i < FIFO_DEPTH) ? 16'h0001 : 16'h0000);
    end
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      dsp.frame(16'(i), 1'b0, dout, ok);
      check(dout, (i < FIFO_DEPTH) ? 16'h0100 + 16'(i) : WORD_ZERO);
    end
    $display("t_fifo_fill_drain finished");
  endtask

  task automatic conclude();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // About 45 frames of 3 us each are expected; this leaves ample margin
  initial begin
    #400000;
    mismatches++;
    conclude();
  end

  initial begin
    mismatches  = 0;
    tests_run   = 0;
    rx_cnt      = 0;
    fsd_cnt     = 0;
    fsd_at      = -1;
    rst_n       = 1'b0;
    fs_delay    = FSD_ZERO;
    gain_sel_hi = 1'b0;
    gain_sel_lo = 1'b1;
    adc_valid   = 1'b0;
    adc_sample  = WORD_ZERO;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_gain_frames();
    t_fs_delay();
    t_fifo_fill_drain();
    conclude();
  end
endmodule // csfp_port_tb
